//--- verilog/bss_status_regs.sv
// Overview of operation
// - bit 19 reads 1 while a secondary INTx message request is pending.
// - bit 20 always reads 1, capability list present at 34h.
// - bit 21 reads 1 in forward bridge mode, 0 in reverse.
// - bit 23 reads 1 only forward with secondary in conventional PCI mode.
// - bit 24 needs parity response enable; reverse: poisoned completion or write.
// - forward: bit 24 on read parity error or parity pin during writes.
// - forward: bit 24 on split completion message reporting write parity error.
// - bits 26:25 read 01 forward, 00 reverse.
// - reverse: bit 27 set when completing a request with completer abort.
// - forward: bit 27 set when signalling target abort.
// - reverse: bit 28 set when completer abort completion received.
// - forward: bit 28 set when target abort detected.
// - reverse: bit 29 set when unsupported request completion received.
// - forward: bit 29 set when master abort detected.
// - reverse: bit 30 set when sending fatal or non-fatal error message.
// - forward: bit 30 set while driving the system error pin.
// - reverse: bit 31 set on poisoned packet, ignoring parity enable.
// - forward: bit 31 set on address or data parity error.
// - bit 6 is read-write parity response enable gating bit 24.
`timescale 1ns/10ps
`default_nettype none
`include "bss_map.svh"

module bss_status_regs (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic fwd_bridge,
  input wire logic sec_pci_mode,
  input wire logic intx_pending,
  input wire logic rev_poisoned_cpl_rx,
  input wire logic rev_write_poisoned,
  input wire logic fwd_read_parity_err,
  input wire logic fwd_write_phase,
  input wire logic bus_parity_error_pin_n,
  input wire logic fwd_split_msg_parity_err,
  input wire logic rev_cpl_abort_sent,
  input wire logic fwd_target_abort_signaled,
  input wire logic rev_cpl_abort_rx,
  input wire logic fwd_target_abort_detected,
  input wire logic rev_cpl_ur_rx,
  input wire logic fwd_master_abort_detected,
  input wire logic rev_err_msg_sent,
  input wire logic system_error_pin_n,
  input wire logic rev_poisoned_tlp_rx,
  input wire logic fwd_addr_parity_err,
  input wire logic fwd_data_parity_err
);
  logic par_en_q;
  logic wr_stb;
  logic hit;
  logic mdpe_set;
  logic [5:0] flag_set;
  logic [5:0] flag_clr;
  logic [5:0] flag;
  logic [1:0] timing;
  bss_pkg::bss_word_t status_word;

  bss_avmm_slave u_slave (
    .ref_clk(ref_clk),
    .rst(rst),
    .address(address),
    .read(read),
    .write(write),
    .rd_word(status_word),
    .waitrequest(waitrequest),
    .readdata(readdata),
    .wr_stb(wr_stb),
    .hit(hit)
  );

  // parity response enable in the command half
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      par_en_q <= `BSS_PAR_EN_RST;
    end else if (wr_stb & byteenable[`BSS_LANE_CMD]) begin
      par_en_q <= writedata[`BSS_BIT_PAR_EN];
    end
  end

  always_comb begin
    if (fwd_bridge) begin
      mdpe_set = par_en_q & (fwd_read_parity_err
        | (fwd_write_phase & ~bus_parity_error_pin_n)
        | fwd_split_msg_parity_err);
    end else begin
      mdpe_set = par_en_q & (rev_poisoned_cpl_rx | rev_write_poisoned);
    end
  end

  // flag order: mdpe, sig tabort, rcv tabort, rcv mabort, sig serr, det perr
  assign flag_set[0] = mdpe_set;
  assign flag_set[1] = fwd_bridge ? fwd_target_abort_signaled : rev_cpl_abort_sent;
  assign flag_set[2] = fwd_bridge ? fwd_target_abort_detected : rev_cpl_abort_rx;
  assign flag_set[3] = fwd_bridge ? fwd_master_abort_detected : rev_cpl_ur_rx;
  assign flag_set[4] = fwd_bridge ? ~system_error_pin_n : rev_err_msg_sent;
  assign flag_set[5] = fwd_bridge ? (fwd_addr_parity_err | fwd_data_parity_err)
    : rev_poisoned_tlp_rx;

  // write one to clear, byte lane 3 only
  assign flag_clr = {6{wr_stb & byteenable[`BSS_LANE_FLAGS]}} & {
    writedata[`BSS_BIT_DET_PERR],
    writedata[`BSS_BIT_SIG_SERR],
    writedata[`BSS_BIT_RCV_MABORT],
    writedata[`BSS_BIT_RCV_TABORT],
    writedata[`BSS_BIT_SIG_TABORT],
    writedata[`BSS_BIT_MDPE]};

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_flag
      bss_event_flag u_flag (
        .ref_clk(ref_clk),
        .rst(rst),
        .set_in(flag_set[gi]),
        .clr_in(flag_clr[gi]),
        .flag(flag[gi])
      );
    end
  endgenerate

  assign timing = fwd_bridge ? `BSS_TIMING_FWD : `BSS_TIMING_REV;

  always_comb begin
    status_word = 32'h00000000;
    status_word[`BSS_BIT_PAR_EN] = par_en_q;
    status_word[`BSS_BIT_INTX] = intx_pending;
    status_word[`BSS_BIT_CAP_LIST] = `BSS_CAP_LIST_VAL;
    status_word[`BSS_BIT_CAP_66] = fwd_bridge;
    status_word[`BSS_BIT_FBB] = fwd_bridge & sec_pci_mode;
    status_word[`BSS_BIT_MDPE] = flag[0];
    status_word[`BSS_TIMING_LSB +: 2] = timing;
    status_word[`BSS_BIT_SIG_TABORT] = flag[1];
    status_word[`BSS_BIT_RCV_TABORT] = flag[2];
    status_word[`BSS_BIT_RCV_MABORT] = flag[3];
    status_word[`BSS_BIT_SIG_SERR] = flag[4];
    status_word[`BSS_BIT_DET_PERR] = flag[5];
  end

  // checks
  logic rd_ans;
  logic wr_clr;
  assign rd_ans = read & ~waitrequest & hit;
  assign wr_clr = wr_stb & byteenable[`BSS_LANE_FLAGS];

  property p_intx;
    @(posedge ref_clk) disable iff (rst)
      read & waitrequest & hit ##1 rd_ans |-> readdata[19] == $past(intx_pending);
  endproperty
  a_intx: assert property (p_intx) else $error("intx bit wrong");

  property p_cap;
    @(posedge ref_clk) disable iff (rst)
      rd_ans |-> readdata[20] == 1'h1;
  endproperty
  a_cap: assert property (p_cap) else $error("capability bit not 1");

  property p_m66;
    @(posedge ref_clk) disable iff (rst)
      read & waitrequest & hit ##1 rd_ans |-> readdata[21] == $past(fwd_bridge);
  endproperty
  a_m66: assert property (p_m66) else $error("66 MHz bit wrong");

  property p_fbb;
    @(posedge ref_clk) disable iff (rst)
      read & waitrequest & hit ##1 rd_ans
        |-> readdata[23] == $past(fwd_bridge & sec_pci_mode);
  endproperty
  a_fbb: assert property (p_fbb) else $error("fast back-to-back bit wrong");

  property p_mdpe_gate;
    @(posedge ref_clk) disable iff (rst)
      $rose(flag[0]) |-> $past(par_en_q);
  endproperty
  a_mdpe_gate: assert property (p_mdpe_gate) else $error("mdpe set while disabled");

  property p_mdpe_rev;
    @(posedge ref_clk) disable iff (rst)
      ~fwd_bridge & par_en_q & (rev_poisoned_cpl_rx | rev_write_poisoned) |=> flag[0];
  endproperty
  a_mdpe_rev: assert property (p_mdpe_rev) else $error("mdpe missed reverse");

  property p_mdpe_pin;
    @(posedge ref_clk) disable iff (rst)
      fwd_bridge & par_en_q & fwd_write_phase & ~bus_parity_error_pin_n
        |=> flag[0] [*1] ##1 (flag[0] | $past(wr_clr));
  endproperty
  a_mdpe_pin: assert property (p_mdpe_pin) else $error("mdpe missed parity pin");

  property p_mdpe_rd;
    @(posedge ref_clk) disable iff (rst)
      fwd_bridge & par_en_q & fwd_read_parity_err |=> flag[0];
  endproperty
  a_mdpe_rd: assert property (p_mdpe_rd) else $error("mdpe missed read parity");

  property p_mdpe_split;
    @(posedge ref_clk) disable iff (rst)
      fwd_bridge & par_en_q & fwd_split_msg_parity_err |=> flag[0];
  endproperty
  a_mdpe_split: assert property (p_mdpe_split) else $error("mdpe missed split msg");

  property p_timing;
    @(posedge ref_clk) disable iff (rst)
      read & waitrequest & hit ##1 rd_ans
        |-> readdata[26:25] == ($past(fwd_bridge) ? 2'h1 : 2'h0);
  endproperty
  a_timing: assert property (p_timing) else $error("timing field wrong");

  property p_sta_rev;
    @(posedge ref_clk) disable iff (rst)
      ~fwd_bridge & rev_cpl_abort_sent |=> flag[1];
  endproperty
  a_sta_rev: assert property (p_sta_rev) else $error("signaled abort missed");

  property p_sta_fwd;
    @(posedge ref_clk) disable iff (rst)
      fwd_bridge & fwd_target_abort_signaled |=> flag[1];
  endproperty
  a_sta_fwd: assert property (p_sta_fwd) else $error("signaled abort missed");

  property p_rta;
    @(posedge ref_clk) disable iff (rst)
      (fwd_bridge ? fwd_target_abort_detected : rev_cpl_abort_rx) |=> flag[2];
  endproperty
  a_rta: assert property (p_rta) else $error("received abort missed");

  property p_rma;
    @(posedge ref_clk) disable iff (rst)
      (fwd_bridge ? fwd_master_abort_detected : rev_cpl_ur_rx) |=> flag[3];
  endproperty
  a_rma: assert property (p_rma) else $error("master abort missed");

  property p_serr;
    @(posedge ref_clk) disable iff (rst)
      (fwd_bridge ? ~system_error_pin_n : rev_err_msg_sent) |=> flag[4];
  endproperty
  a_serr: assert property (p_serr) else $error("system error flag missed");

  property p_dpe_rev;
    @(posedge ref_clk) disable iff (rst)
      ~fwd_bridge & rev_poisoned_tlp_rx |=> flag[5];
  endproperty
  a_dpe_rev: assert property (p_dpe_rev) else $error("poisoned tlp missed");

  property p_dpe_fwd;
    @(posedge ref_clk) disable iff (rst)
      fwd_bridge & (fwd_addr_parity_err | fwd_data_parity_err) |=> flag[5];
  endproperty
  a_dpe_fwd: assert property (p_dpe_fwd) else $error("parity error missed");

  property p_par_en;
    @(posedge ref_clk) disable iff (rst)
      wr_stb & byteenable[0] |=> par_en_q == $past(writedata[6]);
  endproperty
  a_par_en: assert property (p_par_en) else $error("parity enable not written");

  property p_par_en_hold;
    @(posedge ref_clk) disable iff (rst)
      ~(wr_stb & byteenable[0]) |=> $stable(par_en_q);
  endproperty
  a_par_en_hold: assert property (p_par_en_hold) else $error("parity enable moved");

  property p_clear;
    @(posedge ref_clk) disable iff (rst)
      wr_clr & writedata[31] & ~flag_set[5] |=> ~flag[5];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared");

  property p_sticky;
    @(posedge ref_clk) disable iff (rst)
      flag[2] & ~(wr_clr & writedata[28]) |=> flag[2];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped itself");

  property p_reserved;
    @(posedge ref_clk) disable iff (rst)
      rd_ans |-> readdata[18:16] == 3'h0 && readdata[22] == 1'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set");

  property p_reset;
    @(posedge ref_clk)
      rst |=> flag == 6'h00 && par_en_q == 1'h0;
  endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");

  property p_bus_answer;
    @(posedge ref_clk) disable iff (rst)
      (read | write) & waitrequest |=> ~waitrequest;
  endproperty
  a_bus_answer: assert property (p_bus_answer) else $error("bus answer late");

  // flags rise only from the event of the current mode
  property p_sta_cause;
    @(posedge ref_clk) disable iff (rst)
      $rose(flag[1]) |-> $past(fwd_bridge ? fwd_target_abort_signaled : rev_cpl_abort_sent);
  endproperty
  a_sta_cause: assert property (p_sta_cause) else $error("signaled abort wrong mode");

  property p_serr_cause;
    @(posedge ref_clk) disable iff (rst)
      $rose(flag[4]) |-> $past(fwd_bridge ? ~system_error_pin_n : rev_err_msg_sent);
  endproperty
  a_serr_cause: assert property (p_serr_cause) else $error("system error wrong mode");

  property p_dpe_cause;
    @(posedge ref_clk) disable iff (rst)
      $rose(flag[5]) |-> $past(fwd_bridge ? (fwd_addr_parity_err | fwd_data_parity_err)
        : rev_poisoned_tlp_rx);
  endproperty
  a_dpe_cause: assert property (p_dpe_cause) else $error("parity flag wrong mode");

  property p_clear_mdpe;
    @(posedge ref_clk) disable iff (rst)
      wr_clr & writedata[24] & ~mdpe_set |=> ~flag[0];
  endproperty
  a_clear_mdpe: assert property (p_clear_mdpe) else $error("mdpe not cleared");

  // writes land only in the answer cycle
  property p_wr_answer;
    @(posedge ref_clk) disable iff (rst)
      wr_stb |-> write & ~waitrequest;
  endproperty
  a_wr_answer: assert property (p_wr_answer) else $error("write outside answer");

  property p_rd_hold;
    @(posedge ref_clk) disable iff (rst)
      ~(read & waitrequest) |=> $stable(readdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");

  property p_unmapped_rd;
    @(posedge ref_clk) disable iff (rst)
      read & waitrequest & ~hit |=> readdata == 32'h00000000;
  endproperty
  a_unmapped_rd: assert property (p_unmapped_rd) else $error("unmapped read not zero");

  c_read: cover property (@(posedge ref_clk) disable iff (rst) rd_ans);
  c_clear: cover property (@(posedge ref_clk) disable iff (rst) wr_clr & |flag);
  c_set_clr: cover property (@(posedge ref_clk) disable iff (rst) |(flag_set & flag_clr));
  c_mdpe_rev: cover property (@(posedge ref_clk) disable iff (rst) ~fwd_bridge & mdpe_set);
  c_mdpe_fwd: cover property (@(posedge ref_clk) disable iff (rst) fwd_bridge & mdpe_set);
endmodule
`default_nettype wire

//--- verilog/bss_map.svh
`ifndef BSS_MAP_SVH
`define BSS_MAP_SVH

// register byte address: command half low, status half high
`define BSS_ADDR_STATUS 8'h44
`define BSS_ADDR_W 8

// field positions in the 32-bit word
`define BSS_BIT_PAR_EN 6
`define BSS_BIT_INTX 19
`define BSS_BIT_CAP_LIST 20
`define BSS_BIT_CAP_66 21
`define BSS_BIT_FBB 23
`define BSS_BIT_MDPE 24
`define BSS_TIMING_LSB 25
`define BSS_BIT_SIG_TABORT 27
`define BSS_BIT_RCV_TABORT 28
`define BSS_BIT_RCV_MABORT 29
`define BSS_BIT_SIG_SERR 30
`define BSS_BIT_DET_PERR 31

// byte lanes holding writable bits
`define BSS_LANE_CMD 0
`define BSS_LANE_FLAGS 3

// reset and constant values
`define BSS_PAR_EN_RST 1'h0
`define BSS_FLAG_RST 1'h0
`define BSS_CAP_LIST_VAL 1'h1
`define BSS_TIMING_FWD 2'h1
`define BSS_TIMING_REV 2'h0

// bus answer latency in cycles after a request is first seen
`define BSS_BUS_LATENCY 1

`endif

//--- verilog/bss_pkg.sv
package bss_pkg;
  typedef enum logic {
    BSS_BUS_IDLE,
    BSS_BUS_ANSWER
  } bss_bus_state_t;

  typedef logic [31:0] bss_word_t;
endpackage

//--- verilog/bss_event_flag.sv
`timescale 1ns/10ps
`default_nettype none
`include "bss_map.svh"

module bss_event_flag (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic set_in,
  input wire logic clr_in,
  output logic flag
);
  logic flag_q;

  // set wins over a clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= `BSS_FLAG_RST;
    end else if (set_in) begin
      flag_q <= 1'h1;
    end else if (clr_in) begin
      flag_q <= 1'h0;
    end
  end

  assign flag = flag_q;
endmodule
`default_nettype wire

//--- verilog/bss_avmm_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "bss_map.svh"

module bss_avmm_slave (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire bss_pkg::bss_word_t rd_word,
  output logic waitrequest,
  output bss_pkg::bss_word_t readdata,
  output logic wr_stb,
  output logic hit
);
  bss_pkg::bss_bus_state_t state_q;
  bss_pkg::bss_word_t readdata_q;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == `BSS_ADDR_STATUS);
  endfunction

  assign hit = addr_hit(address);
  // first cycle of a request waits, second one answers
  assign waitrequest = (read | write) & (state_q == bss_pkg::BSS_BUS_IDLE);
  assign wr_stb = write & (state_q == bss_pkg::BSS_BUS_ANSWER) & hit;
  assign readdata = readdata_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= bss_pkg::BSS_BUS_IDLE;
    end else begin
      case (state_q)
        bss_pkg::BSS_BUS_IDLE: begin
          if (read | write) begin
            state_q <= bss_pkg::BSS_BUS_ANSWER;
          end
        end
        bss_pkg::BSS_BUS_ANSWER: begin
          state_q <= bss_pkg::BSS_BUS_IDLE;
        end
        default: begin
          state_q <= bss_pkg::BSS_BUS_IDLE;
        end
      endcase
    end
  end

  // unmapped reads return zero
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      readdata_q <= 32'h00000000;
    end else if (read & (state_q == bss_pkg::BSS_BUS_IDLE)) begin
      readdata_q <= addr_hit(address) ? rd_word : 32'h00000000;
    end
  end
endmodule
`default_nettype wire

//--- tb/bss_far_side.sv
`timescale 1ns/10ps
`default_nettype none

module bss_far_side (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic fire,
  input wire logic [3:0] sel,
  output logic [15:0] ev,
  output logic fwd_write_phase,
  output logic bus_parity_error_pin_n,
  output logic system_error_pin_n
);
  // one-cycle event pulse per request; pins idle high as if pulled up
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ev <= 16'h0000;
    end else if (fire) begin
      ev <= 16'h0001 << sel;
    end else begin
      ev <= 16'h0000;
    end
  end

  // parity pin only ever low inside a write phase
  assign fwd_write_phase = ev[3];
  assign bus_parity_error_pin_n = ~ev[3];
  assign system_error_pin_n = ~ev[12];
endmodule

`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h00000000;
  logic [3:0] byteenable = 4'h0;
  logic [31:0] readdata;
  logic waitrequest;
  logic fwd_bridge = 1'b1;
  logic sec_pci_mode = 1'b1;
  logic intx_pending = 1'b0;
  logic fire = 1'b0;
  logic [3:0] sel = 4'h0;
  logic [15:0] ev;
  logic write_phase;
  logic perr_n;
  logic serr_n;
  logic [31:0] got;
  int n_fail = 0;
  int samples_checked = 0;
  // events that belong to forward mode, and the flag each one sets
  localparam logic [15:0] FWD_EV = 16'hD55C;

  function automatic int ev_bit(input int i);
    return (i < 5) ? 24 : (i < 7) ? 27 : (i < 9) ? 28 : (i < 11) ? 29 : (i < 13) ? 30 : 31;
  endfunction

  always #5 ref_clk = ~ref_clk;

  bss_status_regs dut (
    .ref_clk(ref_clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .fwd_bridge(fwd_bridge), .sec_pci_mode(sec_pci_mode),
    .intx_pending(intx_pending), .rev_poisoned_cpl_rx(ev[0]), .rev_write_poisoned(ev[1]),
    .fwd_read_parity_err(ev[2]), .fwd_write_phase(write_phase),
    .bus_parity_error_pin_n(perr_n), .fwd_split_msg_parity_err(ev[4]),
    .rev_cpl_abort_sent(ev[5]), .fwd_target_abort_signaled(ev[6]),
    .rev_cpl_abort_rx(ev[7]), .fwd_target_abort_detected(ev[8]), .rev_cpl_ur_rx(ev[9]),
    .fwd_master_abort_detected(ev[10]), .rev_err_msg_sent(ev[11]),
    .system_error_pin_n(serr_n), .rev_poisoned_tlp_rx(ev[13]),
    .fwd_addr_parity_err(ev[14]), .fwd_data_parity_err(ev[15])
  );

  bss_far_side far_side (
    .ref_clk(ref_clk), .rst(rst), .fire(fire), .sel(sel), .ev(ev),
    .fwd_write_phase(write_phase), .bus_parity_error_pin_n(perr_n),
    .system_error_pin_n(serr_n)
  );

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask

  // waits for waitrequest low at a rising edge; only the watchdog bounds it
  task automatic bus_wait;
    @(posedge ref_clk);
    while (waitrequest !== 1'b0) begin
      @(posedge ref_clk);
    end
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    read <= 1'b1;
    address <= a;
    bus_wait();
    d = readdata;
    read <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    write <= 1'b1;
    address <= a;
    writedata <= d;
    byteenable <= be;
    bus_wait();
    write <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic pulse(input int i);
    fire <= 1'b1;
    sel <= i[3:0];
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  function automatic logic [31:0] exp_word(input logic en, input logic [31:0] fl);
    logic [31:0] w;
    w = fl;
    w[6] = en;
    w[19] = intx_pending;
    w[20] = 1'b1;
    w[21] = fwd_bridge;
    w[23] = fwd_bridge & sec_pci_mode;
    w[26:25] = fwd_bridge ? 2'h1 : 2'h0;
    return w;
  endfunction

  initial begin
    repeat (5000) @(posedge ref_clk);
    $display("BAD watchdog expected done seen hang");
    n_fail++;
    stop_test();
  end

  initial begin
    logic [31:0] e;
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus_rd(8'h44, got);
    chk("reset word", exp_word(1'b0, 32'h0), got);
    for (int m = 0; m < 4; m++) begin
      fwd_bridge <= m[1];
      sec_pci_mode <= m[0];
      intx_pending <= m[0] ^ m[1];
      @(posedge ref_clk);
      bus_rd(8'h44, got);
      chk("mode word", exp_word(1'b0, 32'h0), got);
    end
    intx_pending <= 1'b0;
    $display("test modes done");
    bus_wr(8'h44, 32'h00FFFFFF, 4'hF);
    bus_rd(8'h44, got);
    chk("enable word", exp_word(1'b1, 32'h0), got);
    bus_rd(8'h48, got);
    chk("unmapped read", 32'h00000000, got);
    bus_wr(8'h40, 32'h00000000, 4'hF);
    bus_rd(8'h44, got);
    chk("unmapped write", exp_word(1'b1, 32'h0), got);
    $display("test access done");
    for (int i = 0; i < 16; i++) begin
      for (int wrong = 0; wrong < 2; wrong++) begin
        fwd_bridge <= FWD_EV[i] ^ wrong[0];
        pulse(i);
        e = wrong ? 32'h0 : (32'h1 << ev_bit(i));
        bus_rd(8'h44, got);
        chk("flag set", exp_word(1'b1, e), got);
        bus_wr(8'h44, 32'h00000040, 4'h9);
        bus_rd(8'h44, got);
        chk("flag zero write", exp_word(1'b1, e), got);
        bus_wr(8'h44, 32'hFF000040, 4'h9);
        bus_rd(8'h44, got);
        chk("flag clear", exp_word(1'b1, 32'h0), got);
      end
    end
    $display("test events done");
    // reset in mid-run with a flag and the parity enable set
    fwd_bridge <= 1'b1;
    pulse(14);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus_rd(8'h44, got);
    chk("mid reset word", exp_word(1'b0, 32'h0), got);
    $display("test reset done");
    bus_wr(8'h44, 32'h00000000, 4'h1);
    for (int i = 0; i < 16; i++) begin
      if (i < 5 || i == 13) begin
        fwd_bridge <= FWD_EV[i];
        pulse(i);
        e = (i == 13) ? 32'h80000000 : 32'h0;
        bus_rd(8'h44, got);
        chk("gated flag", exp_word(1'b0, e), got);
        bus_wr(8'h44, 32'hFF000000, 4'h8);
      end
    end
    $display("test gating done");
    stop_test();
  end
endmodule

`default_nettype wire
